// ==== session_pkg.sv ====
// Package of constants and carrier types for the serial session engines
package session_pkg;
   // ----------------------------------------------------------------
   // Message delimiter and buffer type codes
   // ----------------------------------------------------------------
   localparam logic [7:0] ESC_START  = 8'h1B;
   localparam logic [7:0] END_BLOCK  = 8'h17;
   localparam logic [7:0] BUF_TYPE   = 8'h54;

   // ----------------------------------------------------------------
   // Timer defaults in clock cycles (50 MHz)
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 50;
   localparam int BCAST_DELAY_US   = 100;
   localparam int RESP_TIMEOUT_US  = 1000;
   localparam int BUF_TIMEOUT_US   = 1000;
   localparam int BCAST_DELAY_CYC  = BCAST_DELAY_US * CLK_MHZ;
   localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_US * CLK_MHZ;
   localparam int BUF_TIMEOUT_CYC  = BUF_TIMEOUT_US * CLK_MHZ;
   localparam int TMR_W            = 24;

   // ----------------------------------------------------------------
   // Message kinds sent by the engines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MSG_NONE, MSG_ATTACH, MSG_ATT_RESP, MSG_REQUEST,
      MSG_BUFFER, MSG_INTER_RESP, MSG_FINAL_RESP
   } msg_kind_t;

   // Received-message event carrier
   typedef struct packed {
      logic valid;
      logic malformed;
      logic err_report;
      logic err_fatal;
      logic broadcast;
      logic for_other;
      logic with_buf;
   } rx_evt_t;

   // Transmit command carrier
   typedef struct packed {
      logic      valid;
      msg_kind_t kind;
      logic      broadcast;
      logic      error;
      logic      with_buf;
      logic [7:0] start_code;
      logic [7:0] trail_code;
      logic [7:0] next_type;
   } tx_cmd_t;
endpackage

// ==== session_timer.sv ====
// Down-counting expiry timer with start and cancel
`timescale 1ns/1ps
module session_timer (
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire logic                           ce,
   input  wire logic                           start,
   input  wire logic                           cancel,
   input  wire logic [session_pkg::TMR_W-1:0]  load,
   output logic                                expired
);
   logic [session_pkg::TMR_W-1:0] cnt_reg;
   logic                          run_reg;
   logic                          zero_hit;

   // Terminal count detect
   assign zero_hit = run_reg && (cnt_reg == session_pkg::TMR_W'(1));

   // Count down while running; start restarts, cancel stops
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else if (ce) begin
         expired <= zero_hit && !start && !cancel;
         if (start) begin
            cnt_reg <= load;
            run_reg <= 1'b1;
         end else if (cancel || zero_hit) begin
            run_reg <= 1'b0;
            cnt_reg <= '0;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

// ==== session_fsm.sv ====
// Master and slave session state machines for the serial access protocol
`timescale 1ns/1ps
// Function
// - Open: send attach, start broadcast or response timer, await reply.
// - Attach reply cancels timer; malformed aborts to idle, else open.
// - Broadcast delay expiry awaiting attach or final: command done.
// - Open read/write: fetch data, send request, start timer, wait.
// - Inter reply: cancel timer; malformed aborts; else send buffer.
// - Final reply: malformed/fatal aborts; else complete, deliver read data.
// - Final reply awaiting inter: abort if bad, else done with error.
// - Broadcast delay awaiting inter: send buffer, restart delay.
// - Response timeout in any wait state aborts to idle as timeout.
// - Slave: unexpected event aborts to wait-for-break.
// - Slave: long break aborts in any state but wait-for-break, then waits for attach.
// - Attach: bad or foreign to break wait; else reply unless broadcast.
// - Request with reportable error: error reply; fatal to break.
// - Request with buffer: inter reply unless broadcast, buffer timer.
// - Request without buffer: service, final reply unless broadcast.
// - Buffer cancels timer; reportable error: error reply, fatal aborts.
// - Good buffer: service, final reply if request was not broadcast.
// - Buffer timeout aborts slave to wait-for-break.
// - Messages start with 1Bh; 17h marks the trailer.
// - Request with buffer announces type 54h and buffer length.
// - Master: event not allowed in a state aborts to idle.
module session_fsm #(
   parameter int BCAST_DELAY  = session_pkg::BCAST_DELAY_CYC,
   parameter int RESP_TIMEOUT = session_pkg::RESP_TIMEOUT_CYC,
   parameter int BUF_TIMEOUT  = session_pkg::BUF_TIMEOUT_CYC
) (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                ce,
   // Master user side
   input  wire logic                usr_open,
   input  wire logic                usr_bcast,
   input  wire logic                usr_cmd,
   input  wire logic                usr_write,
   input  wire logic                usr_with_buf,
   input  wire logic [15:0]         usr_buf_len,
   input  wire logic [15:0]         usr_wdata,
   // Master receive events
   input  wire session_pkg::rx_evt_t m_att_resp,
   input  wire session_pkg::rx_evt_t m_inter_resp,
   input  wire session_pkg::rx_evt_t m_final_resp,
   input  wire logic [15:0]         m_rdata,
   // Master outputs
   output session_pkg::tx_cmd_t     m_tx,
   output logic [15:0]              m_tx_len,
   output logic [15:0]              m_tx_data,
   output logic                     m_done,
   output logic                     m_done_err,
   output logic                     m_abort,
   output logic                     m_timeout,
   output logic [15:0]              usr_rdata,
   output logic                     usr_rvalid,
   output logic                     m_open,
   // Slave receive events
   input  wire logic                s_long_break,
   input  wire session_pkg::rx_evt_t s_attach,
   input  wire session_pkg::rx_evt_t s_request,
   input  wire session_pkg::rx_evt_t s_buffer,
   // Slave outputs
   output session_pkg::tx_cmd_t     s_tx,
   output logic                     s_service,
   output logic                     s_abort,
   output logic                     s_timeout,
   output logic                     s_state_break
);
   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      M_IDLE, M_WAIT_ATT, M_OPEN, M_WAIT_INTER, M_WAIT_FINAL
   } m_state_t;
   typedef enum logic [1:0] {
      S_WAIT_BREAK, S_WAIT_ATT, S_WAIT_REQ, S_WAIT_BUF
   } s_state_t;

   m_state_t m_state_reg, m_state_next;
   s_state_t s_state_reg, s_state_next;
   logic     m_bcast_reg, m_read_reg, s_bcast_reg;

   // Build a transmit command with the fixed delimiters
   function automatic session_pkg::tx_cmd_t mk_tx(
      input session_pkg::msg_kind_t k, input logic b, input logic e,
      input logic wb);
      session_pkg::tx_cmd_t t;
      t.valid      = (k != session_pkg::MSG_NONE);
      t.kind       = k;
      t.broadcast  = b;
      t.error      = e;
      t.with_buf   = wb;
      t.start_code = session_pkg::ESC_START;
      t.trail_code = session_pkg::END_BLOCK;
      t.next_type  = wb ? session_pkg::BUF_TYPE : 8'h00;
      return t;
   endfunction

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   logic bd_start, rt_start, rt_cancel, bt_start, bt_cancel;
   logic bd_exp, rt_exp, bt_exp, any_m_evt;

   session_timer u_bd (.mclk(mclk), .rst(rst), .ce(ce), .start(bd_start),
      .cancel(m_state_next == M_IDLE || m_state_next == M_OPEN),
      .load(session_pkg::TMR_W'(BCAST_DELAY)), .expired(bd_exp));
   session_timer u_rt (.mclk(mclk), .rst(rst), .ce(ce), .start(rt_start),
      .cancel(rt_cancel), .load(session_pkg::TMR_W'(RESP_TIMEOUT)),
      .expired(rt_exp));
   session_timer u_bt (.mclk(mclk), .rst(rst), .ce(ce), .start(bt_start),
      .cancel(bt_cancel), .load(session_pkg::TMR_W'(BUF_TIMEOUT)),
      .expired(bt_exp));

   assign any_m_evt = usr_open | usr_cmd | m_att_resp.valid
                    | m_inter_resp.valid | m_final_resp.valid;

   // ----------------------------------------------------------------
   // Master next state
   // ----------------------------------------------------------------
   session_pkg::msg_kind_t m_kind;
   logic m_cpl, m_cpl_err, m_abt, m_tmo, m_deliver, m_wb, m_tx_bcast;

   always_comb begin
      m_state_next = m_state_reg;
      m_kind = session_pkg::MSG_NONE;
      m_wb = 1'b0;
      bd_start = 1'b0;
      rt_start = 1'b0;
      rt_cancel = 1'b0;
      m_cpl = 1'b0;
      m_cpl_err = 1'b0;
      m_abt = 1'b0;
      m_tmo = 1'b0;
      m_deliver = 1'b0;
      unique case (m_state_reg)
         M_IDLE: begin
            if (usr_open) begin
               m_kind = session_pkg::MSG_ATTACH;
               bd_start = usr_bcast;
               rt_start = !usr_bcast;
               m_state_next = M_WAIT_ATT;
            end else if (any_m_evt) begin
               m_abt = 1'b1;
            end
         end
         M_WAIT_ATT: begin
            if (m_att_resp.valid) begin
               rt_cancel = 1'b1;
               m_abt = m_att_resp.malformed;
               m_state_next = m_att_resp.malformed ? M_IDLE : M_OPEN;
            end else if (rt_exp) begin
               m_tmo = 1'b1;
               m_abt = 1'b1;
               m_state_next = M_IDLE;
            end else if (bd_exp) begin
               m_cpl = 1'b1;
               m_state_next = M_OPEN;
            end else if (any_m_evt) begin
               m_abt = 1'b1;
               rt_cancel = 1'b1;
               m_state_next = M_IDLE;
            end
         end
         M_OPEN: begin
            if (usr_cmd) begin
               m_kind = session_pkg::MSG_REQUEST;
               m_wb = usr_with_buf;
               bd_start = usr_bcast;
               rt_start = !usr_bcast;
               m_state_next = usr_with_buf ? M_WAIT_INTER : M_WAIT_FINAL;
            end else if (any_m_evt) begin
               m_abt = 1'b1;
               m_state_next = M_IDLE;
            end
         end
         M_WAIT_INTER: begin
            if (m_inter_resp.valid) begin
               rt_cancel = 1'b1;
               if (m_inter_resp.malformed) begin
                  m_abt = 1'b1;
                  m_state_next = M_IDLE;
               end else begin
                  m_kind = session_pkg::MSG_BUFFER;
                  rt_start = 1'b1;
                  m_state_next = M_WAIT_FINAL;
               end
            end else if (m_final_resp.valid) begin
               rt_cancel = 1'b1;
               if (m_final_resp.malformed || m_final_resp.err_fatal) begin
                  m_abt = 1'b1;
                  m_state_next = M_IDLE;
               end else begin
                  m_cpl = 1'b1;
                  m_cpl_err = 1'b1;
                  m_state_next = M_OPEN;
               end
            end else if (rt_exp) begin
               m_tmo = 1'b1;
               m_abt = 1'b1;
               m_state_next = M_IDLE;
            end else if (bd_exp) begin
               m_kind = session_pkg::MSG_BUFFER;
               bd_start = 1'b1;
               m_state_next = M_WAIT_FINAL;
            end else if (any_m_evt) begin
               m_abt = 1'b1;
               rt_cancel = 1'b1;
               m_state_next = M_IDLE;
            end
         end
         M_WAIT_FINAL: begin
            if (m_final_resp.valid) begin
               rt_cancel = 1'b1;
               if (m_final_resp.malformed || m_final_resp.err_fatal) begin
                  m_abt = 1'b1;
                  m_state_next = M_IDLE;
               end else begin
                  m_cpl = 1'b1;
                  m_cpl_err = m_final_resp.err_report;
                  m_deliver = m_read_reg && !m_final_resp.err_report;
                  m_state_next = M_OPEN;
               end
            end else if (rt_exp) begin
               m_tmo = 1'b1;
               m_abt = 1'b1;
               m_state_next = M_IDLE;
            end else if (bd_exp) begin
               m_cpl = 1'b1;
               m_state_next = M_OPEN;
            end else if (any_m_evt) begin
               m_abt = 1'b1;
               rt_cancel = 1'b1;
               m_state_next = M_IDLE;
            end
         end
         default: m_state_next = M_IDLE;
      endcase
   end

   // Buffers carry the stored session broadcast, others follow the user
   assign m_tx_bcast = (m_kind == session_pkg::MSG_BUFFER) ? m_bcast_reg
                                                           : usr_bcast;

   // ----------------------------------------------------------------
   // Slave next state
   // ----------------------------------------------------------------
   session_pkg::msg_kind_t s_kind;
   logic s_err, s_svc, s_abt, s_tmo, any_s_evt;

   assign any_s_evt = s_attach.valid | s_request.valid | s_buffer.valid;

   always_comb begin
      s_state_next = s_state_reg;
      s_kind = session_pkg::MSG_NONE;
      s_err = 1'b0;
      s_svc = 1'b0;
      s_abt = 1'b0;
      s_tmo = 1'b0;
      bt_start = 1'b0;
      bt_cancel = 1'b0;
      if (s_long_break) begin
         s_abt = (s_state_reg != S_WAIT_BREAK);
         bt_cancel = 1'b1;
         s_state_next = S_WAIT_ATT;
      end else begin
         unique case (s_state_reg)
            S_WAIT_BREAK: begin
               s_state_next = S_WAIT_BREAK;
            end
            S_WAIT_ATT: begin
               if (s_attach.valid) begin
                  if (s_attach.malformed || s_attach.for_other) begin
                     s_abt = s_attach.malformed;
                     s_state_next = S_WAIT_BREAK;
                  end else begin
                     if (!s_attach.broadcast)
                        s_kind = session_pkg::MSG_ATT_RESP;
                     s_state_next = S_WAIT_REQ;
                  end
               end else if (any_s_evt) begin
                  s_abt = 1'b1;
                  s_state_next = S_WAIT_BREAK;
               end
            end
            S_WAIT_REQ: begin
               if (s_request.valid) begin
                  if (s_request.err_report) begin
                     s_kind = session_pkg::MSG_FINAL_RESP;
                     s_err = 1'b1;
                     s_abt = s_request.err_fatal;
                     s_state_next = s_request.err_fatal ? S_WAIT_BREAK
                                                        : S_WAIT_REQ;
                  end else if (s_request.with_buf) begin
                     if (!s_request.broadcast)
                        s_kind = session_pkg::MSG_INTER_RESP;
                     bt_start = 1'b1;
                     s_state_next = S_WAIT_BUF;
                  end else begin
                     s_svc = 1'b1;
                     if (!s_request.broadcast)
                        s_kind = session_pkg::MSG_FINAL_RESP;
                  end
               end else if (any_s_evt) begin
                  s_abt = 1'b1;
                  s_state_next = S_WAIT_BREAK;
               end
            end
            S_WAIT_BUF: begin
               if (s_buffer.valid) begin
                  bt_cancel = 1'b1;
                  if (s_buffer.err_report) begin
                     s_kind = session_pkg::MSG_FINAL_RESP;
                     s_err = 1'b1;
                     s_abt = s_buffer.err_fatal;
                     s_state_next = s_buffer.err_fatal ? S_WAIT_BREAK
                                                       : S_WAIT_REQ;
                  end else begin
                     s_svc = 1'b1;
                     if (!s_bcast_reg)
                        s_kind = session_pkg::MSG_FINAL_RESP;
                     s_state_next = S_WAIT_REQ;
                  end
               end else if (bt_exp) begin
                  s_tmo = 1'b1;
                  s_abt = 1'b1;
                  s_state_next = S_WAIT_BREAK;
               end else if (any_s_evt) begin
                  s_abt = 1'b1;
                  bt_cancel = 1'b1;
                  s_state_next = S_WAIT_BREAK;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         m_state_reg <= M_IDLE;
         s_state_reg <= S_WAIT_BREAK;
         m_bcast_reg <= 1'b0;
         m_read_reg  <= 1'b0;
         s_bcast_reg <= 1'b0;
         m_tx        <= '0;
         m_tx_len    <= 16'h0000;
         m_tx_data   <= 16'h0000;
         m_done      <= 1'b0;
         m_done_err  <= 1'b0;
         m_abort     <= 1'b0;
         m_timeout   <= 1'b0;
         usr_rdata   <= 16'h0000;
         usr_rvalid  <= 1'b0;
         m_open      <= 1'b0;
         s_tx        <= '0;
         s_service   <= 1'b0;
         s_abort     <= 1'b0;
         s_timeout   <= 1'b0;
         s_state_break <= 1'b1;
      end else if (ce) begin
         m_state_reg <= m_state_next;
         s_state_reg <= s_state_next;
         if ((m_state_reg == M_IDLE && usr_open)
             || (m_state_reg == M_OPEN && usr_cmd)) begin
            m_bcast_reg <= usr_bcast;
            m_read_reg  <= !usr_write;
         end
         if (m_state_reg == M_OPEN && usr_cmd) begin
            m_tx_len  <= usr_buf_len;
            m_tx_data <= usr_write ? usr_wdata : 16'h0000;
         end
         if (s_state_reg == S_WAIT_REQ && s_request.valid)
            s_bcast_reg <= s_request.broadcast;
         m_tx       <= mk_tx(m_kind, m_tx_bcast, 1'b0, m_wb);
         m_done     <= m_cpl;
         m_done_err <= m_cpl_err;
         m_abort    <= m_abt;
         m_timeout  <= m_tmo;
         usr_rvalid <= m_deliver;
         if (m_deliver)
            usr_rdata <= m_rdata;
         m_open     <= (m_state_next == M_OPEN);
         s_tx       <= mk_tx(s_kind, 1'b0, s_err, 1'b0);
         s_service  <= s_svc;
         s_abort    <= s_abt;
         s_timeout  <= s_tmo;
         s_state_break <= (s_state_next == S_WAIT_BREAK);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   chk_mtimeout_idle: assert property (
      ce && m_tmo |=> m_state_reg == M_IDLE && m_timeout)
      else $error("response timeout did not abort master");
   chk_break_attach: assert property (
      ce && s_long_break |=> s_state_reg == S_WAIT_ATT)
      else $error("long break did not reach wait-for-attach");
   chk_buf_timeout: assert property (
      ce && s_state_reg == S_WAIT_BUF && bt_exp && !s_long_break
      && !s_buffer.valid |=> s_state_break && s_timeout)
      else $error("buffer timeout did not abort slave");
   chk_start_code: assert property (
      s_tx.valid |-> s_tx.start_code == 8'h1B && s_tx.trail_code == 8'h17)
      else $error("bad delimiter codes");
   chk_master_abort: assert property (
      ce && m_abt |=> m_state_reg == M_IDLE && m_abort)
      else $error("master abort did not return to idle");
   chk_slave_abort: assert property (
      ce && s_abt && !s_long_break |=> s_state_break && s_abort)
      else $error("slave abort did not reach wait-for-break");
endmodule

// ==== far_slave_model.sv ====
// Far-side slave model answering the session master
`timescale 1ns/1ps
module far_slave_model #(
   parameter int          DLY   = 3,
   parameter logic [15:0] RDATA = 16'hA5C3
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 mute,
   input  wire session_pkg::tx_cmd_t m_tx,
   output session_pkg::rx_evt_t      att,
   output session_pkg::rx_evt_t      inter,
   output session_pkg::rx_evt_t      fin,
   output logic [15:0]               rdata
);
   session_pkg::msg_kind_t kind_reg;
   logic                   wb_reg;
   logic                   att_v;
   logic                   inter_v;
   logic                   fin_v;
   int                     cnt_reg;
   wire                    framed = m_tx.start_code == session_pkg::ESC_START
      && m_tx.trail_code == session_pkg::END_BLOCK;
   wire                    req = kind_reg == session_pkg::MSG_REQUEST;
   wire                    take = m_tx.valid && !m_tx.broadcast && !mute
      && framed;
   wire                    fire = !rst && !take && cnt_reg == 1;
   // Replies are one-cycle events with every other field low
   assign att = '{valid: att_v, default: 1'b0};
   assign inter = '{valid: inter_v, default: 1'b0};
   assign fin = '{valid: fin_v, default: 1'b0};
   // Take framed directed messages, reply after DLY cycles
   always @(posedge mclk) begin
      att_v <= fire && kind_reg == session_pkg::MSG_ATTACH;
      inter_v <= fire && req && wb_reg;
      fin_v <= fire && (kind_reg == session_pkg::MSG_BUFFER
         || (req && !wb_reg));
      if (rst) begin
         cnt_reg <= 0;
      end else if (take) begin
         kind_reg <= m_tx.kind;
         wb_reg <= m_tx.with_buf
            && m_tx.next_type == session_pkg::BUF_TYPE;
         cnt_reg <= DLY;
      end else if (cnt_reg > 0) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
   // Data line shows the inverse outside the final reply
   assign rdata = fin_v ? RDATA : ~RDATA;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the session state machines
`timescale 1ns/1ps
module tb_top;
   localparam int TM = 20;
   localparam logic [15:0] RD = 16'hA5C3;
   logic mclk = 1'b0, rst = 1'b1, mute = 1'b0;
   logic usr_open = 1'b0, usr_bcast = 1'b0, usr_cmd = 1'b0;
   logic usr_write = 1'b0, usr_with_buf = 1'b0, s_long_break = 1'b0;
   session_pkg::rx_evt_t m_att_resp, m_inter_resp, m_final_resp;
   session_pkg::rx_evt_t s_attach = '0, s_request = '0, s_buffer = '0;
   session_pkg::tx_cmd_t m_tx, s_tx, last_m, last_s;
   logic [15:0] m_rdata, m_tx_len, m_tx_data, usr_rdata;
   logic m_done, m_done_err, m_abort, m_timeout, usr_rvalid, m_open;
   logic s_service, s_abort, s_timeout, s_state_break;
   int cnt [8];
   int err_total = 0, checks_done = 0;
   wire [7:0] pv = {s_timeout, s_abort, s_service, usr_rvalid,
                    m_timeout, m_abort, m_done_err, m_done};
   // Clock and sticky record of messages and pulses
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      if (m_tx.valid) last_m = m_tx;
      if (s_tx.valid) last_s = s_tx;
      for (int i = 0; i < 8; i++)
         cnt[i] = cnt[i] + pv[i];
   end
   session_fsm #(.BCAST_DELAY(TM), .RESP_TIMEOUT(TM), .BUF_TIMEOUT(TM)) i_dut (
      .mclk(mclk), .rst(rst), .ce(1'b1), .usr_open(usr_open),
      .usr_bcast(usr_bcast), .usr_cmd(usr_cmd), .usr_write(usr_write),
      .usr_with_buf(usr_with_buf), .usr_buf_len(16'h001C),
      .usr_wdata(16'h3132), .m_att_resp(m_att_resp),
      .m_inter_resp(m_inter_resp), .m_final_resp(m_final_resp),
      .m_rdata(m_rdata), .m_tx(m_tx), .m_tx_len(m_tx_len),
      .m_tx_data(m_tx_data), .m_done(m_done), .m_done_err(m_done_err),
      .m_abort(m_abort), .m_timeout(m_timeout), .usr_rdata(usr_rdata),
      .usr_rvalid(usr_rvalid), .m_open(m_open),
      .s_long_break(s_long_break), .s_attach(s_attach),
      .s_request(s_request), .s_buffer(s_buffer), .s_tx(s_tx),
      .s_service(s_service), .s_abort(s_abort), .s_timeout(s_timeout),
      .s_state_break(s_state_break));
   far_slave_model #(.DLY(3), .RDATA(RD)) i_far (
      .mclk(mclk), .rst(rst), .mute(mute), .m_tx(m_tx), .att(m_att_resp),
      .inter(m_inter_resp), .fin(m_final_resp), .rdata(m_rdata));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %0h expected %0h",
                  $time, seen, exp);
      end
   endtask
   task settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task m_go(input logic o, c, b, w, wb);
      cnt = '{default: 0};
      @(posedge mclk);
      usr_open <= o;
      usr_cmd <= c;
      usr_bcast <= b;
      usr_write <= w;
      usr_with_buf <= wb;
      @(posedge mclk);
      usr_open <= 1'b0;
      usr_cmd <= 1'b0;
   endtask
   task s_go(input logic lb, input logic [6:0] a, r, b);
      cnt = '{default: 0};
      @(posedge mclk);
      s_long_break <= lb;
      s_attach <= a;
      s_request <= r;
      s_buffer <= b;
      @(posedge mclk);
      s_long_break <= 1'b0;
      s_attach <= '0;
      s_request <= '0;
      s_buffer <= '0;
      settle(3);
   endtask
   task t_master;
      m_go(1, 0, 0, 0, 0);
      settle(10);
      chk(last_m.kind, session_pkg::MSG_ATTACH);
      chk(last_m.start_code, session_pkg::ESC_START);
      chk(last_m.trail_code, session_pkg::END_BLOCK);
      chk(m_open, 1'b1);
      m_go(0, 1, 0, 0, 0);
      settle(10);
      chk(last_m.kind, session_pkg::MSG_REQUEST);
      chk(cnt[4], 1);
      chk(usr_rdata, RD);
      m_go(0, 1, 0, 1, 1);
      settle(20);
      chk(m_tx_len, 16'h001C);
      chk(m_tx_data, 16'h3132);
      chk(last_m.kind, session_pkg::MSG_BUFFER);
      chk(cnt[0] + cnt[1], 1);
      chk(m_open, 1'b1);
      mute <= 1'b1;
      m_go(0, 1, 0, 0, 0);
      settle(TM + 5);
      chk(cnt[3], 1);
      chk(m_open, 1'b0);
      mute <= 1'b0;
      m_go(1, 0, 1, 0, 0);
      settle(TM + 5);
      chk(last_m.broadcast, 1'b1);
      chk(m_open, 1'b1);
      chk(cnt[2], 0);
      chk(cnt[0], 1);
   endtask
   task t_slave;
      chk(s_state_break, 1'b1);
      s_go(1, 0, 0, 0);
      chk(s_state_break, 1'b0);
      s_go(0, 7'h40, 0, 0);
      chk(last_s.kind, session_pkg::MSG_ATT_RESP);
      s_go(0, 0, 7'h40, 0);
      chk(cnt[5], 1);
      chk(last_s.kind, session_pkg::MSG_FINAL_RESP);
      s_go(0, 0, 7'h41, 0);
      chk(last_s.kind, session_pkg::MSG_INTER_RESP);
      s_go(0, 0, 0, 7'h40);
      chk(cnt[5], 1);
      chk(last_s.kind, session_pkg::MSG_FINAL_RESP);
      s_go(0, 0, 7'h41, 0);
      settle(TM + 5);
      chk(cnt[7], 1);
      chk(s_state_break, 1'b1);
      s_go(1, 0, 0, 0);
      s_go(0, 7'h42, 0, 0);
      chk(s_state_break, 1'b1);
      chk(cnt[6], 0);
      s_go(1, 0, 0, 0);
      s_go(0, 7'h40, 0, 0);
      s_go(0, 0, 7'h50, 0);
      chk(last_s.error, 1'b1);
      chk(s_state_break, 1'b0);
      s_go(0, 0, 7'h58, 0);
      chk(last_s.error, 1'b1);
      chk(s_state_break, 1'b1);
      s_go(1, 0, 0, 0);
      s_go(0, 7'h40, 0, 0);
      s_go(0, 0, 0, 7'h40);
      chk(cnt[6], 1);
      chk(s_state_break, 1'b1);
   endtask
   task summarize;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #50000;
      err_total++;
      summarize;
   end
   // Main sequence
   initial begin
      cnt = '{default: 0};
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      settle(1);
      t_master;
      t_slave;
      summarize;
   end
endmodule
